// File: core/dhci_pkg.sv
package dhci_pkg;

  // characters
  localparam logic [7:0] CHR_LF     = 8'h0A;
  localparam logic [7:0] CHR_CR     = 8'h0D;
  localparam logic [7:0] CMD_FLUSH  = 8'h52;
  localparam logic [7:0] CMD_UNSUP  = 8'h55;
  localparam logic [7:0] CMD_AVG    = 8'h41;
  localparam logic [7:0] CMD_SUPP   = 8'h58;
  localparam logic [7:0] CMD_NAV    = 8'h4E;
  localparam logic [7:0] CMD_BEGIN  = 8'h47;
  localparam logic [7:0] CMD_STOP   = 8'h53;
  localparam logic [7:0] ARG_YES    = 8'h59;
  localparam logic [7:0] ARG_NO     = 8'h4E;
  localparam logic [7:0] ARG_PAR    = 8'h49;
  localparam logic [7:0] ARG_SER    = 8'h52;
  localparam logic [7:0] ARG_BOTH   = 8'h42;

  // averaging limits and reset value
  localparam logic [5:0] AVG_MIN    = 6'h01;
  localparam logic [5:0] AVG_MAX    = 6'h32;
  localparam logic [5:0] AVG_RST    = 6'h01;

  // buffer capacities and write sizes in bytes
  localparam logic [14:0] PAR_CAP   = 15'h5014;
  localparam logic [12:0] SER_CAP   = 13'h1F40;
  localparam logic [1:0]  WORD_NB   = 2'h3;
  localparam logic [1:0]  NAV_TAIL  = 2'h1;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CHAR   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_AVG    = 8'h0C;
  localparam logic [7:0] REG_MASK   = 8'h10;
  localparam logic [7:0] REG_PLVL   = 8'h14;
  localparam logic [7:0] REG_SLVL   = 8'h18;

  // status and control field positions
  localparam int ST_COL_PAR = 0;
  localparam int ST_COL_SER = 1;
  localparam int ST_NAV     = 2;
  localparam int ST_ERR_LED = 3;
  localparam int ST_CMD_ERR = 4;
  localparam int ST_OVF_PAR = 5;
  localparam int ST_OVF_SER = 6;
  localparam int CTRL_CLR   = 0;

  typedef struct packed {
    logic [7:0] letter;
    logic [7:0] arg_chr;
    logic [7:0] arg_dec;
    logic [7:0] arg_hex;
    logic [1:0] nargs;
    logic       bad;
  } dhci_cmd_s;

  typedef struct packed {
    logic [23:0] data;
    logic [4:0]  idx;
    logic        is_ad;
  } dhci_word_s;

endpackage

// File: core/dhci_cmd_parse.sv
`timescale 1ns/1ps
module dhci_cmd_parse (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               chr_valid,
  input  wire logic [7:0]         chr,
  input  wire logic               cmd_ack,
  output dhci_pkg::dhci_cmd_s     cmd,
  output logic                    cmd_valid
);
  import dhci_pkg::*;

  dhci_cmd_s  acc_r;
  logic       got_r;
  logic       is_dig;
  logic       is_hexl;
  logic [3:0] nib;

  always_comb begin
    is_dig  = (chr >= 8'h30) && (chr <= 8'h39);
    is_hexl = (chr >= 8'h41) && (chr <= 8'h46);
    nib     = is_dig ? chr[3:0] : (is_hexl ? 4'(chr[3:0] + 4'h9) : 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r     <= '0;
      got_r     <= 1'b0;
      cmd       <= '0;
      cmd_valid <= 1'b0;
    end else begin
      if (cmd_ack)
        cmd_valid <= 1'b0;
      if (chr_valid && !cmd_valid) begin
        if (chr == CHR_LF) begin
          if (got_r) begin
            cmd       <= acc_r;
            cmd_valid <= 1'b1;
          end
          acc_r <= '0;
          got_r <= 1'b0;
        end else if (chr == CHR_CR) begin
          got_r <= got_r;
        end else if (!got_r) begin
          acc_r.letter <= chr;
          got_r        <= 1'b1;
        end else begin
          if (acc_r.nargs == 2'h0)
            acc_r.arg_chr <= chr;
          if (acc_r.nargs == 2'h2)
            acc_r.bad <= 1'b1;
          else
            acc_r.nargs <= 2'(acc_r.nargs + 2'h1);
          acc_r.arg_dec <= 8'(acc_r.arg_dec * 8'd10 + {4'h0, chr[3:0]});
          acc_r.arg_hex <= {acc_r.arg_hex[3:0], nib};
          if (!is_dig)
            acc_r.arg_dec <= 8'hFF;
          // letters other than A-F pass, but poison the hex value
          if (!(is_dig || is_hexl))
            acc_r.arg_hex <= 8'hFF;
        end
      end
    end
  end

endmodule // dhci_cmd_parse

// File: core/dhci_scan_avg.sv
`timescale 1ns/1ps
module dhci_scan_avg (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               restart,
  input  wire logic [5:0]         avg_n,
  input  wire logic               word_valid,
  input  dhci_pkg::dhci_word_s    word_in,
  input  wire logic               scan_end,
  output logic                    out_valid,
  output dhci_pkg::dhci_word_s    out_word,
  output logic                    out_last
);
  import dhci_pkg::*;

  typedef enum {AVG_ACC, AVG_EMIT} dhci_avg_e;

  dhci_avg_e   st_r;
  logic [35:0] sum_r [32];
  logic        ad_r  [32];
  logic [4:0]  nmax_r;
  logic [4:0]  ptr_r;
  logic [5:0]  cnt_r;
  logic [35:0] cur;
  logic [35:0] add;

  always_comb begin
    cur = (cnt_r == 6'h0) ? 36'h0 : sum_r[word_in.idx];
    if (word_in.is_ad)
      add = {18'(cur[35:18] + {6'h0, word_in.data[23:12]}), 18'(cur[17:0] + {6'h0, word_in.data[11:0]})};
    else
      add = 36'(cur + {12'h0, word_in.data});
  end

  always_ff @(posedge pclk) begin
    if (st_r == AVG_ACC && word_valid) begin
      sum_r[word_in.idx] <= add;
      ad_r[word_in.idx]  <= word_in.is_ad;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= AVG_ACC;
      nmax_r    <= 5'h0;
      ptr_r     <= 5'h0;
      cnt_r     <= 6'h0;
      out_valid <= 1'b0;
      out_word  <= '0;
      out_last  <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
      if (restart) begin
        st_r  <= AVG_ACC;
        cnt_r <= 6'h0;
      end else begin
        case (st_r)
          AVG_ACC: begin
            if (word_valid)
              nmax_r <= (cnt_r == 6'h0 || word_in.idx > nmax_r) ? word_in.idx : nmax_r;
            if (scan_end) begin
              if (6'(cnt_r + 6'h1) >= avg_n) begin
                st_r  <= AVG_EMIT;
                ptr_r <= 5'h0;
              end else
                cnt_r <= 6'(cnt_r + 6'h1);
            end
          end
          AVG_EMIT: begin
            out_valid      <= 1'b1;
            out_word.idx   <= ptr_r;
            out_word.is_ad <= ad_r[ptr_r];
            if (ad_r[ptr_r])
              out_word.data <= {12'(sum_r[ptr_r][35:18] / avg_n), 12'(sum_r[ptr_r][17:0] / avg_n)};
            else
              out_word.data <= 24'(sum_r[ptr_r][29:0] / avg_n);
            ptr_r <= 5'(ptr_r + 5'h1);
            if (ptr_r == nmax_r) begin
              out_last <= 1'b1;
              st_r     <= AVG_ACC;
              cnt_r    <= 6'h0;
            end
          end
          default: st_r <= AVG_ACC;
        endcase
      end
    end
  end

endmodule // dhci_scan_avg

// File: core/dhci_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - commands are ascii and end in a line feed
// - a carriage return before the line feed is optional
// - settings hold until the panel reset or a replacing command
// - only the averaging count goes to nonvolatile memory
// - flush empties all buffers, starts nothing, changes nothing else
// - every command but begin and stop also flushes
// - unsuppress returns every word to the scan
// - averaging count sets scans per output, valid 1 to 50
// - suppression drops the word numbered in hex
// - frequency word holds one channel, a/d word holds two
// - navigation Y appends lat/lon to each scan, N does not; code appends once per averaged output
// - begin loads buffers: I parallel, R serial, B both
// - stop ceases loading the buffers
// - buffers hold 20500 parallel bytes and 8000 serial bytes
// - commands and data on either port, serial output in ascii
// - valid-character signal marks each good 8-bit character
// - missing valid character when expected lights the error lamp
module dhci_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ser_rx_valid,
  input  wire logic [7:0]         ser_rx_char,
  input  wire logic               par_rx_valid,
  input  wire logic [7:0]         par_rx_char,
  input  wire logic               panel_reset,
  input  wire logic [5:0]         nv_avg_in,
  output logic                    nv_wr,
  output logic [5:0]              nv_wr_data,
  input  wire logic               scan_word_valid,
  input  dhci_pkg::dhci_word_s    scan_word,
  input  wire logic               scan_end,
  input  wire logic [55:0]        nav_fix,
  input  wire logic               telem_char_valid,
  input  wire logic               telem_char_due,
  output logic                    err_led,
  output logic                    buf_flush,
  output logic                    par_wr,
  output logic [23:0]             par_wr_data,
  output logic [1:0]              par_wr_nbytes,
  input  wire logic               par_rd,
  output logic                    ser_wr,
  output logic [47:0]             ser_wr_data,
  output logic [2:0]              ser_wr_nbytes,
  input  wire logic               ser_rd
);
  import dhci_pkg::*;

  dhci_cmd_s   ser_cmd;
  dhci_cmd_s   par_cmd;
  dhci_cmd_s   cmd;
  logic        ser_cmd_v;
  logic        par_cmd_v;
  logic        cmd_v;
  logic        ser_ack;
  logic        par_ack;
  logic        chr_pend_r;
  logic [7:0]  chr_r;
  logic        par_chr_v;
  logic [7:0]  par_chr;
  logic [5:0]  avg_r;
  logic [31:0] mask_r;
  logic        nav_r;
  logic        col_par_r;
  logic        col_ser_r;
  logic        cmd_err_r;
  logic        nv_load_r;
  logic        flush;
  logic        avg_v;
  dhci_word_s  avg_w;
  logic        avg_last;
  logic [1:0]  nav_step_r;
  logic [55:0] nav_r2;
  logic        go;
  logic [23:0] go_data;
  logic [1:0]  go_nb;
  logic [47:0] go_asc;
  logic [2:0]  go_snb;
  logic [14:0] plvl_r;
  logic [12:0] slvl_r;
  logic        p_ok;
  logic        s_ok;
  logic        ovf_par_r;
  logic        ovf_ser_r;
  logic        seen_r;
  logic        apb_acc;
  logic        apb_wr;
  logic        clr_err;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = psel && penable && pready && pwrite;
  assign clr_err = apb_wr && paddr == REG_CTRL && pwdata[CTRL_CLR];

  // inject apb chars on parallel path
  assign par_chr_v = par_rx_valid || chr_pend_r;
  assign par_chr   = par_rx_valid ? par_rx_char : chr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chr_pend_r <= 1'b0;
      chr_r      <= 8'h00;
    end else if (apb_wr && paddr == REG_CHAR) begin
      chr_pend_r <= 1'b1;
      chr_r      <= pwdata[7:0];
    end else if (!par_rx_valid)
      chr_pend_r <= 1'b0;
  end

  dhci_cmd_parse u_ser_parse (
    .pclk      (pclk),
    .presetn   (presetn),
    .chr_valid (ser_rx_valid),
    .chr       (ser_rx_char),
    .cmd_ack   (ser_ack),
    .cmd       (ser_cmd),
    .cmd_valid (ser_cmd_v)
  );

  dhci_cmd_parse u_par_parse (
    .pclk      (pclk),
    .presetn   (presetn),
    .chr_valid (par_chr_v),
    .chr       (par_chr),
    .cmd_ack   (par_ack),
    .cmd       (par_cmd),
    .cmd_valid (par_cmd_v)
  );

  assign ser_ack = ser_cmd_v;
  assign par_ack = par_cmd_v && !ser_cmd_v;
  assign cmd_v   = ser_cmd_v || par_cmd_v;
  assign cmd     = ser_cmd_v ? ser_cmd : par_cmd;

  // all but begin and stop flush
  assign flush = panel_reset || (cmd_v && cmd.letter != CMD_BEGIN && cmd.letter != CMD_STOP);

  // settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_r     <= AVG_RST;
      mask_r    <= 32'h0000_0000;
      nav_r     <= 1'b0;
      col_par_r <= 1'b0;
      col_ser_r <= 1'b0;
      cmd_err_r <= 1'b0;
      nv_load_r <= 1'b1;
      nv_wr     <= 1'b0;
      nv_wr_data <= AVG_RST;
    end else begin
      nv_wr     <= 1'b0;
      nv_load_r <= 1'b0;
      if (clr_err)
        cmd_err_r <= 1'b0;
      if (nv_load_r || panel_reset) begin
        avg_r <= (nv_avg_in >= AVG_MIN && nv_avg_in <= AVG_MAX) ? nv_avg_in : AVG_RST;
      end
      if (panel_reset) begin
        mask_r    <= 32'h0000_0000;
        nav_r     <= 1'b0;
        col_par_r <= 1'b0;
        col_ser_r <= 1'b0;
      end else if (cmd_v) begin
        if (cmd.bad)
          cmd_err_r <= 1'b1;
        else begin
          case (cmd.letter)
            CMD_FLUSH: cmd_err_r <= cmd_err_r;
            CMD_UNSUP: mask_r <= 32'h0000_0000;
            CMD_AVG: begin
              if (cmd.nargs != 2'h0 && cmd.arg_dec >= {2'h0, AVG_MIN} && cmd.arg_dec <= {2'h0, AVG_MAX}) begin
                avg_r      <= cmd.arg_dec[5:0];
                nv_wr      <= 1'b1;
                nv_wr_data <= cmd.arg_dec[5:0];
              end else
                cmd_err_r <= 1'b1;
            end
            CMD_SUPP: begin
              if (cmd.nargs != 2'h0 && cmd.arg_hex[7:5] == 3'h0)
                mask_r[cmd.arg_hex[4:0]] <= 1'b1;
              else
                cmd_err_r <= 1'b1;
            end
            CMD_NAV: begin
              if (cmd.arg_chr == ARG_YES)
                nav_r <= 1'b1;
              else if (cmd.arg_chr == ARG_NO)
                nav_r <= 1'b0;
              else
                cmd_err_r <= 1'b1;
            end
            CMD_BEGIN: begin
              if (cmd.arg_chr == ARG_PAR || cmd.arg_chr == ARG_BOTH)
                col_par_r <= 1'b1;
              if (cmd.arg_chr == ARG_SER || cmd.arg_chr == ARG_BOTH)
                col_ser_r <= 1'b1;
              if (cmd.arg_chr != ARG_PAR && cmd.arg_chr != ARG_SER && cmd.arg_chr != ARG_BOTH)
                cmd_err_r <= 1'b1;
            end
            CMD_STOP: begin
              col_par_r <= 1'b0;
              col_ser_r <= 1'b0;
            end
            default: cmd_err_r <= 1'b1;
          endcase
        end
      end
    end
  end

  dhci_scan_avg u_avg (
    .pclk       (pclk),
    .presetn    (presetn),
    .restart    (flush),
    .avg_n      (avg_r),
    .word_valid (scan_word_valid),
    .word_in    (scan_word),
    .scan_end   (scan_end),
    .out_valid  (avg_v),
    .out_word   (avg_w),
    .out_last   (avg_last)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nav_step_r <= 2'h0;
      nav_r2     <= 56'h0;
    end else if (flush) begin
      nav_step_r <= 2'h0;
    end else if (avg_last && nav_r) begin
      nav_step_r <= 2'h1;
      nav_r2     <= nav_fix;
    end else if (nav_step_r != 2'h0 && !avg_v) begin
      nav_step_r <= (nav_step_r == 2'h3) ? 2'h0 : 2'(nav_step_r + 2'h1);
    end
  end

  always_comb begin
    go      = 1'b0;
    go_data = 24'h0;
    go_nb   = WORD_NB;
    if (avg_v) begin
      go      = !mask_r[avg_w.idx];
      go_data = avg_w.data;
    end else if (nav_step_r != 2'h0) begin
      go = 1'b1;
      case (nav_step_r)
        2'h1:    go_data = nav_r2[55:32];
        2'h2:    go_data = nav_r2[31:8];
        default: begin
          go_data = {16'h0, nav_r2[7:0]};
          go_nb   = NAV_TAIL;
        end
      endcase
    end
    go_snb = {go_nb, 1'b0};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_asc
      logic [3:0] n;
      assign n = go_data[gi*4 +: 4];
      assign go_asc[gi*8 +: 8] = (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
    end
  endgenerate

  assign p_ok = (16'(plvl_r) + {14'h0, go_nb}) <= {1'b0, PAR_CAP};
  assign s_ok = (14'(slvl_r) + {11'h0, go_snb}) <= {1'b0, SER_CAP};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_wr        <= 1'b0;
      par_wr_data   <= 24'h0;
      par_wr_nbytes <= 2'h0;
      ser_wr        <= 1'b0;
      ser_wr_data   <= 48'h0;
      ser_wr_nbytes <= 3'h0;
      buf_flush     <= 1'b0;
      plvl_r        <= 15'h0;
      slvl_r        <= 13'h0;
      ovf_par_r     <= 1'b0;
      ovf_ser_r     <= 1'b0;
    end else begin
      buf_flush     <= flush;
      par_wr        <= 1'b0;
      ser_wr        <= 1'b0;
      par_wr_data   <= go_data;
      par_wr_nbytes <= go_nb;
      ser_wr_data   <= go_asc;
      ser_wr_nbytes <= go_snb;
      if (clr_err) begin
        ovf_par_r <= 1'b0;
        ovf_ser_r <= 1'b0;
      end
      if (flush) begin
        plvl_r <= 15'h0;
        slvl_r <= 13'h0;
      end else begin
        plvl_r <= 15'(plvl_r - {14'h0, par_rd && plvl_r != 15'h0}
                  + ((go && col_par_r && p_ok) ? {13'h0, go_nb} : 15'h0));
        slvl_r <= 13'(slvl_r - {12'h0, ser_rd && slvl_r != 13'h0}
                  + ((go && col_ser_r && s_ok) ? {10'h0, go_snb} : 13'h0));
        if (go && col_par_r) begin
          par_wr <= p_ok;
          if (!p_ok)
            ovf_par_r <= 1'b1;
        end
        if (go && col_ser_r) begin
          ser_wr <= s_ok;
          if (!s_ok)
            ovf_ser_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r  <= 1'b0;
      err_led <= 1'b0;
    end else begin
      if (telem_char_due) begin
        seen_r <= 1'b0;
        if (!seen_r && !telem_char_valid)
          err_led <= 1'b1;
        else if (panel_reset || clr_err)
          err_led <= 1'b0;
      end else begin
        seen_r <= seen_r || telem_char_valid;
        if (panel_reset || clr_err)
          err_led <= 1'b0;
      end
    end
  end

  // apb read mux
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      REG_CTRL:   rd_mux = 32'h0;
      REG_CHAR:   rd_mux = {31'h0, chr_pend_r};
      REG_STATUS: begin
        rd_mux[ST_COL_PAR] = col_par_r;
        rd_mux[ST_COL_SER] = col_ser_r;
        rd_mux[ST_NAV]     = nav_r;
        rd_mux[ST_ERR_LED] = err_led;
        rd_mux[ST_CMD_ERR] = cmd_err_r;
        rd_mux[ST_OVF_PAR] = ovf_par_r;
        rd_mux[ST_OVF_SER] = ovf_ser_r;
      end
      REG_AVG:    rd_mux = {26'h0, avg_r};
      REG_MASK:   rd_mux = mask_r;
      REG_PLVL:   rd_mux = {17'h0, plvl_r};
      REG_SLVL:   rd_mux = {19'h0, slvl_r};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !rd_hit;
      prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
    end
  end

endmodule // dhci_top

// File: testbench/dhci_sva.sv
`timescale 1ns/1ps
module dhci_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        panel_reset,
  input wire logic        nv_wr,
  input wire logic [5:0]  nv_wr_data,
  input wire logic        telem_char_valid,
  input wire logic        telem_char_due,
  input wire logic        err_led,
  input wire logic        par_wr,
  input wire logic [1:0]  par_wr_nbytes,
  input wire logic        ser_wr,
  input wire logic [47:0] ser_wr_data
);
  import dhci_pkg::*;
  logic seen_r;
  logic clr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign clr = psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[CTRL_CLR];
  function automatic logic hx(input logic [7:0] b);
    return (b >= 8'h30 && b <= 8'h39) || (b >= 8'h41 && b <= 8'h46) || (b >= 8'h61 && b <= 8'h66);
  endfunction
  // valid character seen since the last due slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
    end else if (telem_char_due) begin
      seen_r <= 1'b0;
    end else if (telem_char_valid) begin
      seen_r <= 1'b1;
    end
  end
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no apb answer");
  addr_err_a: assert property (psel && penable && !pready && paddr > REG_SLVL |=> pslverr)
    else $error("no slverr");
  err_set_a: assert property (telem_char_due && !telem_char_valid && !seen_r |=> err_led)
    else $error("led not lit");
  err_hold_a: assert property (err_led && !clr && !panel_reset |=> err_led) else $error("led dropped");
  err_clr_a: assert property (clr && !telem_char_due |=> !err_led) else $error("led not cleared");
  ser_hex_a: assert property (ser_wr |-> hx(ser_wr_data[7:0]) && hx(ser_wr_data[15:8]))
    else $error("not hex");
  par_len_a: assert property (par_wr |-> par_wr_nbytes == 2'h3 || par_wr_nbytes == 2'h1)
    else $error("bad count");
  nv_range_a: assert property (nv_wr |-> nv_wr_data >= AVG_MIN && nv_wr_data <= AVG_MAX)
    else $error("bad avg");
  cover property (par_wr);
  cover property (par_wr && par_wr_nbytes == 2'h1);
  cover property (ser_wr);
  cover property (pslverr);
endmodule // dhci_sva

// File: testbench/dhci_host_model.sv
`timescale 1ns/1ps
module dhci_host_model (
  input  wire logic pclk,
  output logic      tx_valid,
  output logic [7:0] tx_char
);
  import dhci_pkg::*;
  initial begin
    tx_valid = 1'b0;
    tx_char  = 8'h00;
  end
  task automatic send_line(input string s, input logic cr, input int gap);
    logic [7:0] c;
    for (int i = 0; i <= s.len() + 1; i++) begin
      if (i < s.len()) c = s[i];
      else if (i == s.len()) c = CHR_CR;
      else c = CHR_LF;
      if (i != s.len() || cr) begin
        @(posedge pclk);
        tx_valid <= 1'b1;
        tx_char  <= c;
        if (gap > 0) begin
          @(posedge pclk);
          tx_valid <= 1'b0;
          tx_char  <= ~c;
          repeat (gap - 1) @(posedge pclk);
        end
      end
    end
    @(posedge pclk);
    tx_valid <= 1'b0;
    tx_char  <= ~c;
  endtask
endmodule // dhci_host_model

// File: testbench/test_deck_host_command_interpreter.sv
`timescale 1ns/1ps
module test_deck_host_command_interpreter;
  import dhci_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, ser_rx_char, par_rx_char, ra;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, nv_wr, err_led, buf_flush, par_wr, ser_wr, ser_rx_valid, par_rx_valid;
  logic        panel_reset = 1'b0, scan_word_valid = 1'b0, scan_end = 1'b0;
  logic        telem_char_valid = 1'b0, telem_char_due = 1'b0;
  logic [5:0]  nv_wr_data;
  logic [23:0] par_wr_data, v[4];
  logic [1:0]  par_wr_nbytes;
  logic [47:0] ser_wr_data;
  logic [2:0]  ser_wr_nbytes;
  logic [24:0] s;
  logic [12:0] hi_s, lo_s;
  logic [55:0] nav_fix = 56'h0;
  dhci_word_s  scan_word = '0;
  logic [32:0] rd_q[$], pw_q[$];
  int          err_total = 0, checks = 0, nfl = 0, n0;
  string       tc[18] = '{"R", "U", "X3", "X1F", "U", "NY", "GB", "S", "GR", "S", "GI", "S", "NN", "A1",
                          "A50", "A0", "A51", "Q"};
  logic [32:0] te[18] = '{33'h0, 33'h0, 33'h8, 33'h80000008, 33'h0, 33'h4, 33'h7, 33'h4, 33'h6, 33'h4,
                          33'h5, 33'h4, 33'h0, 33'h1, 33'h32, 33'h32, 33'h32, 33'h10};
  dhci_top u_dhci_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ser_rx_valid, .ser_rx_char, .par_rx_valid, .par_rx_char, .panel_reset, .nv_avg_in(6'h07),
    .nv_wr, .nv_wr_data, .scan_word_valid, .scan_word, .scan_end, .nav_fix,
    .telem_char_valid, .telem_char_due, .err_led, .buf_flush, .par_wr, .par_wr_data,
    .par_wr_nbytes, .par_rd(1'b0), .ser_wr, .ser_wr_data, .ser_wr_nbytes, .ser_rd(1'b0)
  );
  dhci_host_model u_dhci_host_model (.pclk, .tx_valid(ser_rx_valid), .tx_char(ser_rx_char));
  dhci_host_model u_par_host (.pclk, .tx_valid(par_rx_valid), .tx_char(par_rx_char));
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input string c);
    // host picks serial or parallel port
    if ($urandom % 2) u_dhci_host_model.send_line(c, 1'($urandom), $urandom % 3);
    else u_par_host.send_line(c, 1'($urandom), $urandom % 3);
    repeat (4) @(posedge pclk);
  endtask
  task automatic scan(input logic [23:0] a, input logic [23:0] b);
    @(posedge pclk);
    scan_word_valid <= 1'b1;
    scan_word       <= {a, 5'h00, 1'b0};
    @(posedge pclk);
    scan_word       <= {b, 5'h01, 1'b1};
    @(posedge pclk);
    scan_word_valid <= 1'b0;
    scan_end        <= 1'b1;
    @(posedge pclk);
    scan_end <= 1'b0;
    repeat (40) @(posedge pclk);
  endtask
  task automatic tel(input logic val);
    @(posedge pclk);
    telem_char_valid <= val;
    @(posedge pclk);
    telem_char_valid <= 1'b0;
    telem_char_due   <= 1'b1;
    @(posedge pclk);
    telem_char_due <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && !pwrite) chk({pslverr, prdata}, rd_q.pop_front());
    if (par_wr === 1'b1) chk(33'({par_wr_nbytes, par_wr_data}), pw_q.pop_front());
    if (buf_flush === 1'b1) nfl++;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(43));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(REG_AVG, 33'h7);
    rd(8'h40, 33'h100000000);
    $display("test reset done");
    // host sends unsuppress before any suppression
    foreach (tc[i]) begin
      n0 = nfl;
      cmd(tc[i]);
      chk(33'(nfl - n0), 33'(tc[i][0] != "G" && tc[i][0] != "S"));
      ra = tc[i][0] == "A" ? REG_AVG : (tc[i][0] == "U" || tc[i][0] == "X") ? REG_MASK : REG_STATUS;
      rd(ra, te[i]);
    end
    apb(1'b1, REG_CTRL, 32'h1);
    rd(REG_STATUS, 33'h0);
    $display("test commands done");
    cmd("A2");
    cmd("GB");
    foreach (v[i]) v[i] = 24'($urandom);
    s    = {1'b0, v[0]} + v[2];
    hi_s = {1'b0, v[1][23:12]} + v[3][23:12];
    lo_s = {1'b0, v[1][11:0]} + v[3][11:0];
    pw_q.push_back({2'h3, s[24:1]});
    pw_q.push_back({2'h3, hi_s[12:1], lo_s[12:1]});
    scan(v[0], v[1]);
    scan(v[2], v[3]);
    rd(REG_PLVL, 33'h6);
    rd(REG_SLVL, 33'hC);
    cmd("S");
    scan(v[0], v[1]);
    scan(v[2], v[3]);
    chk(33'(pw_q.size()), 33'h0);
    rd(REG_PLVL, 33'h6);
    $display("test data done");
    cmd("NY");
    cmd("GI");
    nav_fix <= {$urandom, 24'($urandom)};
    @(posedge pclk);
    pw_q.push_back({2'h3, s[24:1]});
    pw_q.push_back({2'h3, hi_s[12:1], lo_s[12:1]});
    pw_q.push_back({2'h3, nav_fix[55:32]});
    pw_q.push_back({2'h3, nav_fix[31:8]});
    pw_q.push_back({2'h1, 16'h0, nav_fix[7:0]});
    scan(v[0], v[1]);
    scan(v[2], v[3]);
    rd(REG_PLVL, 33'hD);
    @(posedge pclk);
    panel_reset <= 1'b1;
    @(posedge pclk);
    panel_reset <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(REG_AVG, 33'h7);
    rd(REG_STATUS, 33'h0);
    rd(REG_PLVL, 33'h0);
    $display("test panel done");
    tel(1'b0);
    chk({32'h0, err_led}, 33'h1);
    apb(1'b1, REG_CTRL, 32'h1);
    tel(1'b1);
    chk({32'h0, err_led}, 33'h0);
    $display("test lamp done");
    finish_test();
  end
endmodule // test_deck_host_command_interpreter
bind dhci_top dhci_sva u_dhci_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .panel_reset,
  .nv_wr, .nv_wr_data, .telem_char_valid, .telem_char_due, .err_led, .par_wr, .par_wr_nbytes,
  .ser_wr, .ser_wr_data
);
